// ---- sfb_defines.vh ----
/*
 Offsets, field positions, reset values and timing counts for the bank-one
 special function register block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SFB_DEFINES_VH
`define SFB_DEFINES_VH

`define SFB_OFS_INDIRECT_ACCESS_PORT 8'h80
`define SFB_OFS_OPTION_CONFIG 8'h81
`define SFB_OFS_PC_LOW_BYTE 8'h82
`define SFB_OFS_CPU_FLAGS 8'h83
`define SFB_OFS_INDIRECT_POINTER 8'h84
`define SFB_OFS_PORT_A_DIRECTION 8'h85
`define SFB_OFS_PORT_B_DIRECTION 8'h86
`define SFB_OFS_PORT_C_DIRECTION 8'h87
`define SFB_OFS_PORT_D_DIRECTION 8'h88
`define SFB_OFS_PORT_E_DIRECTION_PSP_FLAGS 8'h89
`define SFB_OFS_PC_HIGH_LATCH 8'h8a
`define SFB_OFS_INTERRUPT_CONTROL 8'h8b
`define SFB_OFS_PERIPHERAL_IRQ_ENABLE_1 8'h8c
`define SFB_OFS_PERIPHERAL_IRQ_ENABLE_2 8'h8d
`define SFB_OFS_POWER_RESET_CAUSE 8'h8e
`define SFB_OFS_TIMER2_PERIOD 8'h92
`define SFB_OFS_SYNC_SERIAL_OWN_ADDRESS 8'h93
`define SFB_OFS_SYNC_SERIAL_STATE 8'h94
`define SFB_OFS_ASYNC_TX_CONTROL 8'h98
`define SFB_OFS_BAUD_DIVISOR 8'h99
`define SFB_OFS_ANALOG_PIN_CONFIG 8'h9f
`define SFB_OFS_CORE_CONTROL 8'hc0

`define SFB_RST_OPTION_CONFIG 8'hff
`define SFB_RST_PC_LOW_BYTE 8'h00
`define SFB_RST_CPU_FLAGS 8'h18
`define SFB_RST_INDIRECT_POINTER 8'h00
`define SFB_RST_PORT_A_DIRECTION 8'h3f
`define SFB_RST_PORT_B_DIRECTION 8'hff
`define SFB_RST_PORT_C_DIRECTION 8'hff
`define SFB_RST_PORT_D_DIRECTION 8'hff
`define SFB_RST_PORT_E_DIRECTION_PSP_FLAGS 8'h07
`define SFB_RST_PC_HIGH_LATCH 8'h00
`define SFB_RST_INTERRUPT_CONTROL 8'h00
`define SFB_RST_PERIPHERAL_IRQ_ENABLE_1 8'h00
`define SFB_RST_PERIPHERAL_IRQ_ENABLE_2 8'h00
`define SFB_RST_TIMER2_PERIOD 8'hff
`define SFB_RST_SYNC_SERIAL_OWN_ADDRESS 8'h00
`define SFB_RST_SYNC_SERIAL_STATE 8'h00
`define SFB_RST_ASYNC_TX_CONTROL 8'h02
`define SFB_RST_BAUD_DIVISOR 8'h00
`define SFB_RST_ANALOG_PIN_CONFIG 8'h00

`define SFB_MASK_PORT_A_DIRECTION 8'h3f
`define SFB_MASK_PC_HIGH_LATCH 8'h1f
`define SFB_MASK_PORT_E_DIRECTION 8'hf7
`define SFB_MASK_PERIPHERAL_IRQ_ENABLE_2 8'h01
`define SFB_MASK_ASYNC_TX_CONTROL 8'hf5
`define SFB_MASK_ANALOG_PIN_CONFIG 8'h07
`define SFB_MASK_SYNC_SERIAL_STATE 8'hc0
`define SFB_MASK_CPU_FLAGS_WR 8'he7
`define SFB_MASK_POWER_RESET_CAUSE 8'h03

`define SFB_BIT_PSP_IRQ_ENABLE 7
`define SFB_BIT_CPU_FLAGS_TIMEOUT 4
`define SFB_BIT_CPU_FLAGS_POWERDOWN 3
`define SFB_BIT_POR_FLAG 1
`define SFB_BIT_BOR_FLAG 0
`define SFB_BIT_CTL_SMALL_PACKAGE 0

`define SFB_PC_HIGH_WIDTH 5
`define SFB_EXT_RESET_SETTLE 4'h3

`endif

// ---- sfb_pin_sync.v ----
/*
 Three-stage synchroniser with agreement filter for one pin input.
 Assumes the pin is asynchronous to pclk.
*/
`timescale 1ns/100ps
`default_nettype none
module sfb_pin_sync #(
    parameter RESET_LEVEL = 1'b1
) (
    input wire pclk,
    input wire presetn,
    input wire pin,
    output reg level
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= RESET_LEVEL;
            s2 <= RESET_LEVEL;
            s3 <= RESET_LEVEL;
            level <= RESET_LEVEL;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            // Change counts only once the second and third stages agree
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sfb_reset_gen.v ----
/*
 Combines synchronised pin reset and watchdog timeout into one soft reset,
 held while the pin is low, that reloads register reset states.
 Assumes watchdog_timeout is a pclk-domain pulse.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sfb_defines.vh"
module sfb_reset_gen (
    input wire pclk,
    input wire presetn,
    input wire external_reset_pin_n,
    input wire watchdog_timeout,
    output reg soft_reset,
    output reg pin_reset_seen,
    output reg wdt_reset_seen
);
    wire pin_level;
    sfb_pin_sync #(.RESET_LEVEL(1'b1)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(external_reset_pin_n),
        .level(pin_level)
    );
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset <= 1'b0;
            pin_reset_seen <= 1'b0;
            wdt_reset_seen <= 1'b0;
        end else begin
            // Held while the pin is low, so a long pin reset holds registers at reset
            soft_reset <= ~pin_level | watchdog_timeout;
            pin_reset_seen <= ~pin_level;
            wdt_reset_seen <= watchdog_timeout;
        end
    end
endmodule
`default_nettype wire

// ---- sfb_bank.v ----
/*
 Bank-one special function register decode and storage on APB.
 Assumes an APB master on pclk; core data memory reachable through the
 mem_* port for indirect accesses; branch strobe from the core.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "sfb_defines.vh"
module sfb_bank #(
    parameter SMALL_PACKAGE = 1'b0
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata_out,
    output wire pready,
    output wire pslverr,
    input wire external_reset_pin_n,
    input wire watchdog_timeout,
    input wire brownout_detect,
    input wire branch_strobe,
    output reg [4:0] pc_upper,
    output reg mem_req,
    output reg mem_write,
    output reg [7:0] mem_addr,
    output reg [7:0] mem_wdata,
    input wire mem_ack,
    input wire [7:0] mem_rdata,
    output wire [7:0] option_config_out,
    output wire [7:0] port_a_dir_out,
    output wire [7:0] port_b_dir_out,
    output wire [7:0] port_c_dir_out,
    output wire [7:0] port_d_dir_out,
    output wire [7:0] port_e_dir_out,
    output wire [7:0] pc_low_out,
    output wire [7:0] cpu_flags_out,
    output wire [7:0] interrupt_control_out
);
    localparam ST_IDLE = 2'b00;
    localparam ST_MEM = 2'b01;
    localparam ST_DONE = 2'b10;

    // Offset table: register index i sits at the word for reg_ofs(i)
    localparam NREG = 20;
    reg [7:0] regs [0:NREG-1];
    reg [1:0] state;
    reg [31:0] prdata;
    reg small_pkg;
    reg [7:0] core_ctl;
    reg [7:0] next_rdata;
    reg [7:0] wmask;
    reg [4:0] hit_idx;
    reg hit;
    wire soft_reset;
    wire wdt_seen;
    wire [7:0] word_addr;
    wire setup;
    wire is_indirect;
    wire is_ctl;
    integer k;
    integer j;

    function [7:0] reg_ofs;
        input [4:0] i;
        begin
            case (i)
                5'd0: reg_ofs = `SFB_OFS_OPTION_CONFIG;
                5'd1: reg_ofs = `SFB_OFS_PC_LOW_BYTE;
                5'd2: reg_ofs = `SFB_OFS_CPU_FLAGS;
                5'd3: reg_ofs = `SFB_OFS_INDIRECT_POINTER;
                5'd4: reg_ofs = `SFB_OFS_PORT_A_DIRECTION;
                5'd5: reg_ofs = `SFB_OFS_PORT_B_DIRECTION;
                5'd6: reg_ofs = `SFB_OFS_PORT_C_DIRECTION;
                5'd7: reg_ofs = `SFB_OFS_PORT_D_DIRECTION;
                5'd8: reg_ofs = `SFB_OFS_PORT_E_DIRECTION_PSP_FLAGS;
                5'd9: reg_ofs = `SFB_OFS_PC_HIGH_LATCH;
                5'd10: reg_ofs = `SFB_OFS_INTERRUPT_CONTROL;
                5'd11: reg_ofs = `SFB_OFS_PERIPHERAL_IRQ_ENABLE_1;
                5'd12: reg_ofs = `SFB_OFS_PERIPHERAL_IRQ_ENABLE_2;
                5'd13: reg_ofs = `SFB_OFS_POWER_RESET_CAUSE;
                5'd14: reg_ofs = `SFB_OFS_TIMER2_PERIOD;
                5'd15: reg_ofs = `SFB_OFS_SYNC_SERIAL_OWN_ADDRESS;
                5'd16: reg_ofs = `SFB_OFS_SYNC_SERIAL_STATE;
                5'd17: reg_ofs = `SFB_OFS_ASYNC_TX_CONTROL;
                5'd18: reg_ofs = `SFB_OFS_BAUD_DIVISOR;
                5'd19: reg_ofs = `SFB_OFS_ANALOG_PIN_CONFIG;
                default: reg_ofs = 8'h00;
            endcase
        end
    endfunction

    // Writable bit mask; status-only bits are left out
    function [7:0] reg_wmask;
        input [4:0] i;
        begin
            case (i)
                5'd2: reg_wmask = `SFB_MASK_CPU_FLAGS_WR;
                5'd4: reg_wmask = `SFB_MASK_PORT_A_DIRECTION;
                5'd8: reg_wmask = `SFB_MASK_PORT_E_DIRECTION;
                5'd9: reg_wmask = `SFB_MASK_PC_HIGH_LATCH;
                5'd12: reg_wmask = `SFB_MASK_PERIPHERAL_IRQ_ENABLE_2;
                5'd13: reg_wmask = `SFB_MASK_POWER_RESET_CAUSE;
                5'd16: reg_wmask = `SFB_MASK_SYNC_SERIAL_STATE;
                5'd17: reg_wmask = `SFB_MASK_ASYNC_TX_CONTROL;
                5'd19: reg_wmask = `SFB_MASK_ANALOG_PIN_CONFIG;
                default: reg_wmask = 8'hff;
            endcase
        end
    endfunction

    function [7:0] reg_rst;
        input [4:0] i;
        begin
            case (i)
                5'd0: reg_rst = `SFB_RST_OPTION_CONFIG;
                5'd1: reg_rst = `SFB_RST_PC_LOW_BYTE;
                5'd2: reg_rst = `SFB_RST_CPU_FLAGS;
                5'd3: reg_rst = `SFB_RST_INDIRECT_POINTER;
                5'd4: reg_rst = `SFB_RST_PORT_A_DIRECTION;
                5'd5: reg_rst = `SFB_RST_PORT_B_DIRECTION;
                5'd6: reg_rst = `SFB_RST_PORT_C_DIRECTION;
                5'd7: reg_rst = `SFB_RST_PORT_D_DIRECTION;
                5'd8: reg_rst = `SFB_RST_PORT_E_DIRECTION_PSP_FLAGS;
                5'd9: reg_rst = `SFB_RST_PC_HIGH_LATCH;
                5'd10: reg_rst = `SFB_RST_INTERRUPT_CONTROL;
                5'd11: reg_rst = `SFB_RST_PERIPHERAL_IRQ_ENABLE_1;
                5'd12: reg_rst = `SFB_RST_PERIPHERAL_IRQ_ENABLE_2;
                5'd14: reg_rst = `SFB_RST_TIMER2_PERIOD;
                5'd15: reg_rst = `SFB_RST_SYNC_SERIAL_OWN_ADDRESS;
                5'd16: reg_rst = `SFB_RST_SYNC_SERIAL_STATE;
                5'd17: reg_rst = `SFB_RST_ASYNC_TX_CONTROL;
                5'd18: reg_rst = `SFB_RST_BAUD_DIVISOR;
                5'd19: reg_rst = `SFB_RST_ANALOG_PIN_CONFIG;
                default: reg_rst = 8'h00;
            endcase
        end
    endfunction

    sfb_reset_gen u_rst (
        .pclk(pclk),
        .presetn(presetn),
        .external_reset_pin_n(external_reset_pin_n),
        .watchdog_timeout(watchdog_timeout),
        .soft_reset(soft_reset),
        .pin_reset_seen(),
        .wdt_reset_seen(wdt_seen)
    );

    // Mirror bits above the bank offset are dropped so every bank hits
    assign word_addr = {1'b1, paddr[8:2]};
    assign setup = psel & ~penable & (state == ST_IDLE);
    assign is_indirect = (word_addr == `SFB_OFS_INDIRECT_ACCESS_PORT);
    assign is_ctl = (paddr[9:2] == `SFB_OFS_CORE_CONTROL);

    // Address decode over the table; no match means unimplemented
    always @* begin
        hit = 1'b0;
        hit_idx = 5'd0;
        for (j = 0; j < NREG; j = j + 1) begin
            if (reg_ofs(j[4:0]) == word_addr && !hit) begin
                hit = 1'b1;
                hit_idx = j[4:0];
            end
        end
        // Small package drops port D and E direction registers
        if (small_pkg && (hit_idx == 5'd7 || hit_idx == 5'd8)) begin
            hit = 1'b0;
        end
        // Only mirrored registers answer outside bank one
        if (paddr[10:9] != 2'b01 && !(hit_idx == 5'd1 || hit_idx == 5'd2 ||
            hit_idx == 5'd3 || hit_idx == 5'd9 || hit_idx == 5'd10)) begin
            hit = 1'b0;
        end
        wmask = hit ? reg_wmask(hit_idx) : 8'h00;
        next_rdata = hit ? (regs[hit_idx] & reg_wmask_rd(hit_idx)) : 8'h00;
        if (is_ctl) begin
            next_rdata = core_ctl;
        end
    end

    // Readable bits: status bits readable though not writable
    function [7:0] reg_wmask_rd;
        input [4:0] i;
        begin
            case (i)
                5'd4: reg_wmask_rd = `SFB_MASK_PORT_A_DIRECTION;
                5'd8: reg_wmask_rd = `SFB_MASK_PORT_E_DIRECTION;
                5'd9: reg_wmask_rd = `SFB_MASK_PC_HIGH_LATCH;
                5'd12: reg_wmask_rd = `SFB_MASK_PERIPHERAL_IRQ_ENABLE_2;
                5'd13: reg_wmask_rd = `SFB_MASK_POWER_RESET_CAUSE;
                5'd17: reg_wmask_rd = `SFB_MASK_ASYNC_TX_CONTROL | 8'h02;
                5'd19: reg_wmask_rd = `SFB_MASK_ANALOG_PIN_CONFIG;
                default: reg_wmask_rd = 8'hff;
            endcase
        end
    endfunction

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            prdata <= 32'h0000_0000;
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 8'h00;
            mem_wdata <= 8'h00;
            pc_upper <= 5'h00;
            core_ctl <= 8'h00;
            small_pkg <= 1'b0;
            for (k = 0; k < NREG; k = k + 1) begin
                regs[k] <= reg_rst(k[4:0]);
            end
            // Power-up sets the power-on flag and clears the brown-out flag
            regs[13] <= 8'h02;
        end else begin
            small_pkg <= SMALL_PACKAGE | core_ctl[`SFB_BIT_CTL_SMALL_PACKAGE];
            if (branch_strobe) begin
                pc_upper <= regs[9][4:0];
            end
            case (state)
                ST_IDLE: begin
                    if (setup && is_indirect) begin
                        mem_req <= 1'b1;
                        mem_write <= pwrite;
                        mem_addr <= regs[3];
                        mem_wdata <= pwdata[7:0];
                        state <= ST_MEM;
                    end else if (setup) begin
                        prdata <= {24'h00_0000, next_rdata};
                        state <= ST_DONE;
                    end
                end
                ST_MEM: begin
                    if (mem_ack) begin
                        mem_req <= 1'b0;
                        prdata <= {24'h00_0000,
                            mem_write ? 8'h00 : mem_rdata};
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // Write lands on the edge that completes the access
                    if (psel && penable && pwrite) begin
                        if (is_ctl) begin
                            core_ctl <= pwdata[7:0];
                        end else begin
                            regs[hit_idx] <= (regs[hit_idx] & ~wmask) |
                                (pwdata[7:0] & wmask);
                        end
                    end
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
            // Hardware clear beats a software write in the same cycle
            if (brownout_detect) begin
                regs[13][`SFB_BIT_BOR_FLAG] <= 1'b0;
            end
            if (small_pkg) begin
                regs[11][`SFB_BIT_PSP_IRQ_ENABLE] <= 1'b0;
            end
            // Non-power-up reset: reload reset states, keep cause register
            if (soft_reset) begin
                for (k = 0; k < NREG; k = k + 1) begin
                    if (k != 13) begin
                        regs[k] <= reg_rst(k[4:0]);
                    end
                end
                if (wdt_seen) begin
                    regs[2][`SFB_BIT_CPU_FLAGS_TIMEOUT] <= 1'b0;
                end
                pc_upper <= 5'h00;
                mem_req <= 1'b0;
                state <= ST_IDLE;
            end
        end
    end

    assign pready = (state == ST_DONE);
    assign pslverr = 1'b0;
    assign prdata_out = prdata;
    assign option_config_out = regs[0];
    assign pc_low_out = regs[1];
    assign cpu_flags_out = regs[2];
    assign port_a_dir_out = regs[4] & `SFB_MASK_PORT_A_DIRECTION;
    assign port_b_dir_out = regs[5];
    assign port_c_dir_out = regs[6];
    assign port_d_dir_out = small_pkg ? 8'h00 : regs[7];
    assign port_e_dir_out = small_pkg ? 8'h00 : regs[8];
    assign interrupt_control_out = regs[10];
    // Upper program counter byte has no register location of its own
endmodule
`default_nettype wire

// ---- sfb_bank_props.sv ----
/*
 Concurrent checks on the ports of the bank-one register block.
 Assumes one pclk domain; byte address is offset times four.
*/
`timescale 1ns/100ps
`default_nettype none
module sfb_bank_props (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire [31:0] paddr,
    input wire [31:0] prdata_out,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire external_reset_pin_n,
    input wire watchdog_timeout,
    input wire branch_strobe,
    input wire [4:0] pc_upper,
    input wire mem_req,
    input wire [7:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire mem_ack,
    input wire [7:0] option_config_out,
    input wire [7:0] port_b_dir_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Cycles since the last pin or watchdog reset; soft reset may move pc_upper
    logic [3:0] calm;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calm <= 4'h0;
        end else if (!external_reset_pin_n || watchdog_timeout) begin
            calm <= 4'h0;
        end else if (calm != 4'hf) begin
            calm <= calm + 4'h1;
        end
    end
    sequence reg_setup;
        psel && !penable && paddr[8:2] != 7'h00;
    endsequence
    sequence ind_setup;
        psel && !penable && paddr[8:2] == 7'h00;
    endsequence
    reg_answer_a: assert property (reg_setup |=> pready)
        else $error("register access not answered next cycle");
    ind_req_a: assert property (ind_setup |-> ##[1:3] mem_req)
        else $error("indirect access made no memory request");
    ind_ready_a: assert property (pready && psel && paddr[8:2] == 7'h00
        |-> $past(mem_ack))
        else $error("indirect access answered before memory");
    req_hold_a: assert property (mem_req && !mem_ack |=> mem_req &&
        $stable(mem_addr) && $stable(mem_wdata))
        else $error("memory request changed before acknowledge");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    upper_zero_a: assert property (pready && !pwrite
        |-> prdata_out[31:8] == 24'h00_0000)
        else $error("unused read data bits not zero");
    wdt_reload_a: assert property (watchdog_timeout
        |-> ##[1:6] option_config_out == 8'hff)
        else $error("watchdog did not reload option register");
    pin_reload_a: assert property (!external_reset_pin_n [*8]
        |-> port_b_dir_out == 8'hff)
        else $error("pin reset did not reload direction register");
    pc_hold_a: assert property (calm == 4'hf && !branch_strobe &&
        !$past(branch_strobe) |=> $stable(pc_upper))
        else $error("upper counter moved without a branch");
    no_error_a: assert property (pready |-> !pslverr)
        else $error("error response returned");
endmodule
bind sfb_bank sfb_bank_props u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .paddr(paddr), .pwrite(pwrite),
    .prdata_out(prdata_out), .pready(pready), .pslverr(pslverr),
    .external_reset_pin_n(external_reset_pin_n),
    .watchdog_timeout(watchdog_timeout), .branch_strobe(branch_strobe),
    .pc_upper(pc_upper), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .option_config_out(option_config_out),
    .port_b_dir_out(port_b_dir_out));
`default_nettype wire

// ---- sfb_mem_model.sv ----
/*
 Core data memory answering indirect requests after a set delay.
 Assumes the bank holds its request until mem_ack.
*/
`timescale 1ns/100ps
`default_nettype none
module sfb_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [7:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic [3:0] delay,
    output logic mem_ack,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:255];
    logic [7:0] last;
    logic [3:0] cnt;
    logic served;
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5a;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_ack <= 1'b0;
            mem_rdata <= 8'h00;
            last <= 8'h00;
            cnt <= 4'h0;
            served <= 1'b0;
        end else begin
            mem_ack <= 1'b0;
            // Data is not held outside the acknowledge cycle
            mem_rdata <= ~last;
            if (!mem_req) begin
                served <= 1'b0;
                cnt <= 4'h0;
            end else if (!served && cnt == delay) begin
                mem_ack <= 1'b1;
                served <= 1'b1;
                if (mem_write) begin
                    mem[mem_addr] <= mem_wdata;
                end else begin
                    mem_rdata <= mem[mem_addr];
                    last <= mem[mem_addr];
                end
            end else if (!served) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- sfr_bank1_decode_tb.sv ----
/*
 Self-checking bench for the bank-one register block over APB.
 Assumes the memory model answers indirect requests.
*/
`timescale 1ns/100ps
`default_nettype none
module sfr_bank1_decode_tb;
    logic pclk, presetn, psel, penable, pwrite, watchdog_timeout;
    logic external_reset_pin_n, brownout_detect, branch_strobe;
    logic [31:0] paddr, pwdata, rd;
    logic [3:0] delay;
    wire [31:0] prdata_out;
    wire pready, pslverr, mem_req, mem_write, mem_ack;
    wire [4:0] pc_upper;
    wire [7:0] mem_addr, mem_wdata, mem_rdata, option_config_out;
    wire [7:0] port_b_dir_out, port_d_dir_out, pc_low_out;
    wire [7:0] interrupt_control_out, cpu_flags_out;
    int fail_count, cmp_count;
    // Offset in the high byte, reset value in the low byte
    logic [15:0] rst_tab [0:21] = '{16'h81ff, 16'h8200, 16'h8318,
        16'h8400, 16'h853f, 16'h86ff, 16'h87ff, 16'h88ff, 16'h8907,
        16'h8a00, 16'h8b00, 16'h8c00, 16'h8d00, 16'h8e02, 16'h92ff,
        16'h9300, 16'h9400, 16'h9802, 16'h9900, 16'h9f00, 16'h8f00,
        16'h9500};
    sfb_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata_out(prdata_out), .pready(pready),
        .pslverr(pslverr), .external_reset_pin_n(external_reset_pin_n),
        .watchdog_timeout(watchdog_timeout),
        .brownout_detect(brownout_detect), .branch_strobe(branch_strobe),
        .pc_upper(pc_upper), .mem_req(mem_req), .mem_write(mem_write),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .option_config_out(option_config_out),
        .port_a_dir_out(), .port_b_dir_out(port_b_dir_out),
        .port_c_dir_out(), .port_d_dir_out(port_d_dir_out),
        .port_e_dir_out(), .pc_low_out(pc_low_out),
        .cpu_flags_out(cpu_flags_out),
        .interrupt_control_out(interrupt_control_out));
    sfb_mem_model mdl (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
        .mem_write(mem_write), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .delay(delay), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    task report_and_stop;
        $display("checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp,
        input string msg);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    task apb(input logic w, input logic [7:0] ofs, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {22'h00_0000, ofs, 2'b00};
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Ready and read data are taken at the rising edge itself
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("wrong value at %0t: no ready", $time);
            report_and_stop;
        end
        rd = prdata_out;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask
    task wr(input logic [7:0] ofs, input logic [7:0] d);
        apb(1'b1, ofs, d);
    endtask
    task rdchk(input logic [7:0] ofs, input logic [7:0] exp,
        input string msg);
        apb(1'b0, ofs, 8'h00);
        chk(rd[7:0], exp, msg);
    endtask
    task strobe;
        @(posedge pclk);
        branch_strobe <= 1'b1;
        @(posedge pclk);
        branch_strobe <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
    endtask
    task t_reset;
        foreach (rst_tab[i]) begin
            rdchk(rst_tab[i][15:8], rst_tab[i][7:0], "reset value");
        end
    endtask
    task t_masks;
        wr(8'h8a, 8'hff);
        rdchk(8'h8a, 8'h1f, "latch width");
        wr(8'h8d, 8'hff);
        rdchk(8'h8d, 8'h01, "enable two width");
        wr(8'h8f, 8'h5a);
        rdchk(8'h8f, 8'h00, "gap write");
        rdchk(8'h81, 8'hff, "gap side effect");
        wr(8'h98, 8'h00);
        rdchk(8'h98, 8'h02, "read-only bit");
    endtask
    task t_mirror;
        wr(8'h0a, 8'h0b);
        rdchk(8'h8a, 8'h0b, "latch mirror");
        wr(8'h8b, 8'h55);
        rdchk(8'h0b, 8'h55, "control mirror");
        chk(interrupt_control_out, 8'h55, "control out");
        wr(8'h06, 8'h00);
        chk(port_b_dir_out, 8'hff, "unmirrored write");
    endtask
    task t_branch;
        wr(8'h8a, 8'h15);
        strobe;
        chk({3'b000, pc_upper}, 8'h15, "copy on branch");
        wr(8'h8a, 8'h0a);
        repeat (3) @(posedge pclk);
        chk({3'b000, pc_upper}, 8'h15, "copy without branch");
        wr(8'h82, 8'h77);
        chk(pc_low_out, 8'h77, "low byte");
        chk({3'b000, pc_upper}, 8'h15, "low byte write");
        strobe;
        chk({3'b000, pc_upper}, 8'h0a, "second branch");
    endtask
    task t_indirect;
        wr(8'h84, 8'h30);
        wr(8'h80, 8'ha5);
        chk(mdl.mem[8'h30], 8'ha5, "indirect write");
        @(posedge pclk);
        delay <= 4'h3;
        rdchk(8'h80, 8'ha5, "slow indirect read");
        wr(8'h84, 8'h31);
        rdchk(8'h00, 8'h6b, "indirect mirror");
        rdchk(8'h84, 8'h31, "pointer kept");
    endtask
    task t_small;
        wr(8'hc0, 8'h01);
        wr(8'h88, 8'h0f);
        rdchk(8'h88, 8'h00, "absent port d");
        rdchk(8'h89, 8'h00, "absent port e");
        chk(port_d_dir_out, 8'h00, "port d out");
        wr(8'h8c, 8'h7f);
        rdchk(8'h8c, 8'h7f, "enable one");
        wr(8'hc0, 8'h00);
    endtask
    task t_resets;
        wr(8'h81, 8'h00);
        @(posedge pclk);
        watchdog_timeout <= 1'b1;
        @(posedge pclk);
        watchdog_timeout <= 1'b0;
        repeat (6) @(posedge pclk);
        rdchk(8'h81, 8'hff, "watchdog reload");
        rdchk(8'h83, 8'h08, "timeout flag");
        chk(cpu_flags_out, 8'h08, "flags out");
        wr(8'h86, 8'h00);
        @(posedge pclk);
        external_reset_pin_n <= 1'b0;
        repeat (10) @(posedge pclk);
        external_reset_pin_n <= 1'b1;
        repeat (8) @(posedge pclk);
        rdchk(8'h86, 8'hff, "pin reload");
        rdchk(8'h8a, 8'h00, "pin reload latch");
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        external_reset_pin_n = 1'b1;
        watchdog_timeout = 1'b0;
        brownout_detect = 1'b0;
        branch_strobe = 1'b0;
        delay = 4'h0;
        fail_count = 0;
        cmp_count = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_masks;
        t_mirror;
        t_branch;
        t_indirect;
        t_small;
        t_resets;
        report_and_stop;
    end
endmodule
`default_nettype wire
